// *** verilog/gss_servo.sv ***
// Gray-scale servo loop sequencer, counter and latches
// Functional notes
// - Sample three lines, one per colour.
// - First half bright, second half dark.
// - Six loops: three dark, three bright.
// - Seven-bit latches hold values between samples.
// - Upper comparator counts the counter up.
// - Lower comparator counts the counter down.
// - Between thresholds the counter holds.
// - Load copies counter into serviced latch.
// - Backload copies latch into counter first.
// - Sequencer on line/field timing picks latch.
// - Three host intensity latches feed references.
// - Dark reference is intensity over ten.
// - Bright reference pulse follows contrast.
// - Host bit freezes loops, latches retained.
// - Brightness is common pedestal outside loops.
// - Offset loop runs only in field flyback.
// - Reference outside limits raises grid flags.
// - Settings come from host serial interface.
`timescale 1ns/10ps
`default_nettype none
`include "gss_defs.svh"
module gss_servo
	import gss_pkg::*;
#(
	parameter int LINE_CYC = `GSS_LINE_CYC
) (
	// Clock and reset
	input  wire logic              CLK,
	input  wire logic              RST_N,
	// Timing pins
	input  wire logic              LINE_START,
	input  wire logic              SAMPLE_WINDOW,
	input  wire logic              FIELD_FLYBACK,
	// Comparator pins
	input  wire logic              UPPER_ERROR_COMPARATOR,
	input  wire logic              LOWER_ERROR_COMPARATOR,
	// Host settings
	input  wire gss_ctrl_t         CTRL,
	input  wire logic [20:0]       INTENSITY,
	input  wire logic [6:0]        LIMIT_HI,
	input  wire logic [6:0]        LIMIT_LO,
	// Converter outputs
	output logic [20:0]            DC_LEVEL,
	output logic [20:0]            GAIN,
	output logic [20:0]            REF_LEVEL,
	output logic [6:0]             OFFSET_LOOP_CONVERTER,
	output logic [20:0]            PEDESTAL,
	output logic                   BRIGHT_PERIOD,
	output logic                   DARK_PERIOD,
	output logic [6:0]             REF_PULSE,
	// Status
	output gss_flags_t             FLAGS,
	output logic [2:0]             ACTIVE_CHANNEL
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [4:0] s1_q;
	logic [4:0] s2_q;
	logic       line_prev_q;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s1_q <= 5'h00;
			s2_q <= 5'h00;
			line_prev_q <= 1'b0;
		end else begin
			s1_q <= {LINE_START, SAMPLE_WINDOW, FIELD_FLYBACK,
				UPPER_ERROR_COMPARATOR, LOWER_ERROR_COMPARATOR};
			s2_q <= s1_q;
			line_prev_q <= s2_q[4];
		end
	end

	logic line_edge;
	logic win;
	logic flyback;
	logic cmp_up;
	logic cmp_dn;
	assign line_edge = s2_q[4] & ~line_prev_q;
	assign win = s2_q[3];
	assign flyback = s2_q[2];
	assign cmp_up = s2_q[1];
	assign cmp_dn = s2_q[0];

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	gss_state_t state_q;
	logic [1:0]  chan_q;
	logic        dark_q;
	logic [15:0] cyc_q;
	logic        adj_offs_q;

	logic half_done;
	logic line_done;
	assign half_done = (cyc_q >= 16'(LINE_CYC / 2 - 4));
	assign line_done = (cyc_q >= 16'(LINE_CYC - 4));

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= GSS_IDLE;
			chan_q <= 2'h0;
			dark_q <= 1'b0;
			cyc_q <= 16'h0000;
			adj_offs_q <= 1'b0;
		end else begin
			case (state_q)
				GSS_IDLE: begin
					cyc_q <= 16'h0000;
					dark_q <= 1'b0;
					adj_offs_q <= 1'b0;
					if (flyback && !win && CTRL.loops_on) begin
						adj_offs_q <= 1'b1;
						state_q <= GSS_BACKLOAD;
					end else if (win && line_edge) begin
						state_q <= GSS_BACKLOAD;
					end
				end
				GSS_BACKLOAD: begin
					cyc_q <= cyc_q + 16'h0001;
					state_q <= adj_offs_q ? GSS_OFFSET : GSS_ADJUST;
				end
				GSS_ADJUST: begin
					cyc_q <= cyc_q + 16'h0001;
					if (dark_q ? line_done : half_done)
						state_q <= GSS_LOAD;
				end
				GSS_OFFSET: begin
					if (!flyback)
						state_q <= GSS_LOAD;
				end
				GSS_LOAD: begin
					cyc_q <= cyc_q + 16'h0001;
					state_q <= GSS_NEXT;
				end
				GSS_NEXT: begin
					if (adj_offs_q) begin
						state_q <= GSS_IDLE;
					end else if (!dark_q) begin
						dark_q <= 1'b1;
						state_q <= GSS_BACKLOAD;
					end else begin
						dark_q <= 1'b0;
						cyc_q <= 16'h0000;
						chan_q <= (chan_q == 2'h2) ? 2'h0 : chan_q + 2'h1;
						state_q <= GSS_IDLE;
					end
				end
				default: state_q <= GSS_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Up/down counter
	// ----------------------------------------
	logic [6:0] cnt_q;
	logic [6:0] sel_val;
	logic [6:0] dc_q [3];
	logic [6:0] gain_q [3];
	logic [6:0] offs_q;

	always_comb begin
		if (adj_offs_q)
			sel_val = offs_q;
		else if (dark_q)
			sel_val = dc_q[chan_q];
		else
			sel_val = gain_q[chan_q];
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cnt_q <= `GSS_VAL_RST;
		end else if (state_q == GSS_BACKLOAD) begin
			cnt_q <= sel_val;
		end else if ((state_q == GSS_ADJUST || state_q == GSS_OFFSET) && CTRL.loops_on) begin
			if (cmp_up && !cmp_dn && cnt_q != `GSS_VAL_MAX)
				cnt_q <= cnt_q + 7'h01;
			else if (cmp_dn && !cmp_up && cnt_q != 7'h00)
				cnt_q <= cnt_q - 7'h01;
			else
				cnt_q <= cnt_q;
		end
	end

	// ----------------------------------------
	// Latches, six loops plus offset
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `GSS_CH_N; g++) begin : g_ch
			always_ff @(posedge CLK or negedge RST_N) begin
				if (!RST_N) begin
					dc_q[g] <= `GSS_VAL_RST;
					gain_q[g] <= `GSS_VAL_RST;
				end else if (state_q == GSS_LOAD && !adj_offs_q && chan_q == 2'(g)
					&& CTRL.loops_on) begin
					if (dark_q)
						dc_q[g] <= cnt_q;
					else
						gain_q[g] <= cnt_q;
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			offs_q <= `GSS_OFFS_RST;
		else if (state_q == GSS_LOAD && adj_offs_q && CTRL.loops_on)
			offs_q <= cnt_q;
	end

	// ----------------------------------------
	// Converter and reference outputs
	// ----------------------------------------
	logic [6:0] int_ch;
	logic       lim_hi;
	logic       lim_lo;
	assign int_ch = INTENSITY[7*chan_q +: 7];
	assign lim_hi = (INTENSITY[6:0] > LIMIT_HI) || (INTENSITY[13:7] > LIMIT_HI)
		|| (INTENSITY[20:14] > LIMIT_HI);
	assign lim_lo = (INTENSITY[6:0] < LIMIT_LO) || (INTENSITY[13:7] < LIMIT_LO)
		|| (INTENSITY[20:14] < LIMIT_LO);

	logic in_adjust;
	assign in_adjust = (state_q == GSS_ADJUST);

	// Latch converters
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			DC_LEVEL <= 21'h000000;
			GAIN <= 21'h000000;
			OFFSET_LOOP_CONVERTER <= 7'h00;
		end else begin
			DC_LEVEL <= {dc_q[2], dc_q[1], dc_q[0]};
			GAIN <= {gain_q[2], gain_q[1], gain_q[0]};
			OFFSET_LOOP_CONVERTER <= offs_q;
		end
	end

	// Host references and pedestal
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			REF_LEVEL <= 21'h000000;
			PEDESTAL <= 21'h000000;
		end else begin
			REF_LEVEL <= INTENSITY;
			PEDESTAL <= {3{CTRL.brightness}};
		end
	end

	// Adjust half markers
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			BRIGHT_PERIOD <= 1'b0;
			DARK_PERIOD <= 1'b0;
		end else begin
			BRIGHT_PERIOD <= in_adjust && !dark_q;
			DARK_PERIOD <= in_adjust && dark_q;
		end
	end

	// Reference pulse
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			REF_PULSE <= 7'h00;
		end else begin
			if (in_adjust && !dark_q)
				REF_PULSE <= CTRL.contrast;
			else if (in_adjust)
				REF_PULSE <= 7'(int_ch / `GSS_DARK_DIV);
			else
				REF_PULSE <= 7'h00;
		end
	end

	// Screen-grid flags
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			FLAGS <= '0;
		end else begin
			FLAGS.grid_up <= lim_hi;
			FLAGS.grid_down <= lim_lo;
		end
	end

	// Channel in service
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ACTIVE_CHANNEL <= 3'h0;
		end else begin
			ACTIVE_CHANNEL <= (state_q == GSS_IDLE) ? 3'h0 : 3'(3'h1 << chan_q);
		end
	end

endmodule
`default_nettype wire

// *** verilog/gss_defs.svh ***
// Constants for the gray-scale servo sequencer
`ifndef GSS_DEFS_SVH
`define GSS_DEFS_SVH
`define GSS_VAL_W        7
`define GSS_VAL_MAX      7'h7f
`define GSS_VAL_RST      7'h40
`define GSS_CH_N         3
`define GSS_DARK_DIV     8'h0a
`define GSS_LINE_CYC     16'h0a00
`define GSS_LIM_HI_RST   7'h70
`define GSS_LIM_LO_RST   7'h08
`define GSS_OFFS_RST     7'h40
`endif

// *** verilog/gss_pkg.sv ***
// Types for the gray-scale servo sequencer
package gss_pkg;
	typedef enum logic [5:0] {
		GSS_IDLE      = 6'b000001,
		GSS_BACKLOAD  = 6'b000010,
		GSS_ADJUST    = 6'b000100,
		GSS_LOAD      = 6'b001000,
		GSS_NEXT      = 6'b010000,
		GSS_OFFSET    = 6'b100000
	} gss_state_t;

	typedef struct packed {
		logic       loops_on;
		logic [6:0] contrast;
		logic [6:0] brightness;
	} gss_ctrl_t;

	typedef struct packed {
		logic grid_up;
		logic grid_down;
	} gss_flags_t;
endpackage

// *** verif/gss_servo_asserts.sv ***
// Port assertions for the gray-scale servo sequencer
`timescale 1ns/10ps
`default_nettype none
module gss_servo_asserts
	import gss_pkg::*;
(
	// Clock and reset
	input wire logic        CLK,
	input wire logic        RST_N,
	// Watched ports
	input wire gss_ctrl_t   CTRL,
	input wire logic [20:0] INTENSITY,
	input wire logic [20:0] REF_LEVEL,
	input wire logic [20:0] PEDESTAL,
	input wire logic [20:0] GAIN,
	input wire logic        BRIGHT_PERIOD,
	input wire logic        DARK_PERIOD,
	input wire logic [6:0]  REF_PULSE,
	input wire logic [2:0]  ACTIVE_CHANNEL
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	sequence s_frozen; !CTRL.loops_on [*3]; endsequence
	sequence s_bright_held; BRIGHT_PERIOD ##1 BRIGHT_PERIOD; endsequence
	property p_ped; 1 |=> PEDESTAL == {3{$past(CTRL.brightness)}}; endproperty
	a_ped: assert property (p_ped) else $error("pedestal wrong");
	property p_lvl; 1 |=> REF_LEVEL == $past(INTENSITY); endproperty
	a_lvl: assert property (p_lvl) else $error("reference level wrong");
	property p_excl; !(BRIGHT_PERIOD && DARK_PERIOD); endproperty
	a_excl: assert property (p_excl) else $error("both halves active");
	property p_chan; $onehot0(ACTIVE_CHANNEL); endproperty
	a_chan: assert property (p_chan) else $error("channel not one-hot");
	property p_frozen; s_frozen |=> $stable(GAIN); endproperty
	a_frozen: assert property (p_frozen) else $error("gain moved while off");
	property p_dark; $fell(BRIGHT_PERIOD) |-> ##[1:6] DARK_PERIOD; endproperty
	a_dark: assert property (p_dark) else $error("no dark half");
	property p_br; s_bright_held |-> REF_PULSE == $past(CTRL.contrast); endproperty
	a_br: assert property (p_br) else $error("bright pulse wrong");
	property p_idle; !BRIGHT_PERIOD && !DARK_PERIOD |-> REF_PULSE == 7'h00; endproperty
	a_idle: assert property (p_idle) else $error("pulse outside halves");
endmodule
bind gss_servo gss_servo_asserts gss_servo_asserts_inst (.CLK(CLK), .RST_N(RST_N),
	.CTRL(CTRL), .INTENSITY(INTENSITY), .REF_LEVEL(REF_LEVEL), .PEDESTAL(PEDESTAL),
	.GAIN(GAIN), .BRIGHT_PERIOD(BRIGHT_PERIOD), .DARK_PERIOD(DARK_PERIOD),
	.REF_PULSE(REF_PULSE), .ACTIVE_CHANNEL(ACTIVE_CHANNEL));
`default_nettype wire

// *** verif/gss_cathode_amp.sv ***
// Cathode amplifier feedback model driving the error comparators
`timescale 1ns/10ps
`default_nettype none
module gss_cathode_amp (
	// Clock and timing
	input  wire logic       clk,
	input  wire logic       dark_period,
	input  wire logic       flyback,
	input  wire logic [2:0] active,
	// Error direction: bright [3:2], dark [1:0]
	input  wire logic [3:0] mode,
	// Comparators
	output logic            upper,
	output logic            lower
);
	logic junk_q = 1'b0;
	logic dark_q = 1'b0;
	always_ff @(posedge clk) begin
		junk_q <= !junk_q;
		dark_q <= (dark_q || dark_period) && (active != 3'h0);
	end
	// Error sense per half, noise outside lines
	always_comb begin
		if (flyback) {upper, lower} = mode[3:2];
		else if (active == 3'h0) {upper, lower} = {junk_q, !junk_q};
		else if (dark_q || dark_period) {upper, lower} = mode[1:0];
		else {upper, lower} = mode[3:2];
	end
endmodule
`default_nettype wire

// *** verif/test_gss_servo.sv ***
// Self-checking bench for the gray-scale servo sequencer
`timescale 1ns/10ps
`default_nettype none
module test_gss_servo;
	import gss_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, ls = 1'b0, win = 1'b0, fly = 1'b0, up, dn, br, dk;
	logic [3:0] mode = 4'h0;
	gss_ctrl_t ctrl = '0;
	logic [20:0] inten = '0, dc, gain, lvl, ped;
	logic [6:0] offs, pulse;
	logic [2:0] chan;
	logic [6:0] lim_hi = 7'h70, lim_lo = 7'h08;
	gss_flags_t flg;
	logic [15:0] lfsr = 16'h2a2c;
	int error_cnt = 0, comparisons = 0, cyc = 0;
	gss_servo #(.LINE_CYC(64)) gss_servo_inst (.CLK(clk), .RST_N(rst_n), .LINE_START(ls),
		.SAMPLE_WINDOW(win), .FIELD_FLYBACK(fly), .UPPER_ERROR_COMPARATOR(up),
		.LOWER_ERROR_COMPARATOR(dn), .CTRL(ctrl), .INTENSITY(inten), .LIMIT_HI(lim_hi),
		.LIMIT_LO(lim_lo), .DC_LEVEL(dc), .GAIN(gain), .REF_LEVEL(lvl),
		.OFFSET_LOOP_CONVERTER(offs), .PEDESTAL(ped), .BRIGHT_PERIOD(br), .DARK_PERIOD(dk),
		.REF_PULSE(pulse), .FLAGS(flg), .ACTIVE_CHANNEL(chan));
	gss_cathode_amp gss_cathode_amp_inst (.clk(clk), .dark_period(dk), .flyback(fly),
		.active(chan), .mode(mode), .upper(up), .lower(dn));
	always #12.5 clk = !clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 12000) begin
			error_cnt++;
			end_sim;
		end
	end
	task automatic end_sim;
		if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [20:0] got, input logic [20:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// New random settings from the shift register
	task automatic settings(input logic on);
		lfsr = nxt(nxt(lfsr));
		inten = {inten[4:0], lfsr};
		lfsr = nxt(nxt(lfsr));
		ctrl = {on, lfsr[13:0]};
		lim_hi = lfsr[14:8] | 7'h40;
		lim_lo = lfsr[6:0] & 7'h3f;
	endtask
	// Integer model of the grid limit flags
	function automatic logic [1:0] exp_flags();
		int hi = 0;
		int lo = 0;
		for (int k = 0; k < 3; k++) begin
			if (int'((inten >> (7 * k)) & 21'h7f) > int'(lim_hi)) hi = 1;
			if (int'((inten >> (7 * k)) & 21'h7f) < int'(lim_lo)) lo = 1;
		end
		return {hi[0], lo[0]};
	endfunction
	// Sample lines red, green, blue per field
	task automatic field(input int n);
		int v;
		int exp_q[$];
		repeat (n) begin
			win = 1'b1;
			for (int k = 0; k < 3; k++) begin
				v = int'((inten >> (7 * k)) & 21'h7f);
				exp_q.push_back(int'(ctrl.contrast));
				exp_q.push_back(v / 10);
				repeat (4) @(negedge clk);
				ls = 1'b1;
				repeat (3) @(negedge clk);
				ls = 1'b0;
				repeat (20) @(negedge clk);
				check(21'(chan), 21'(1 << k));
				check(21'(flg), 21'(exp_flags()));
				check(21'(pulse), 21'(exp_q.pop_front()));
				repeat (30) @(negedge clk);
				check(21'(pulse), 21'(exp_q.pop_front()));
				repeat (40) @(negedge clk);
			end
			win = 1'b0;
			@(negedge clk);
		end
	endtask
	initial begin
		settings(1'b1);
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		check(gain, {3{7'h40}});
		check(dc, {3{7'h40}});
		check(ped, {3{ctrl.brightness}});
		check(lvl, inten);
		check(21'(flg), 21'(exp_flags()));
		mode = 4'b0011;
		field(1);
		check(gain, {3{7'h40}});
		check(dc, {3{7'h40}});
		mode = 4'b1001;
		field(5);
		check(gain, {3{7'h7f}});
		check(dc, 21'h0);
		ctrl.contrast = ctrl.contrast >> 1;
		field(1);
		settings(1'b0);
		mode = 4'b0110;
		field(2);
		check(gain, {3{7'h7f}});
		check(dc, 21'h0);
		ctrl.loops_on = 1'b1;
		field(6);
		check(gain, 21'h0);
		check(dc, {3{7'h7f}});
		check(21'(offs), 21'h40);
		mode = 4'b1000;
		fly = 1'b1;
		repeat (300) @(negedge clk);
		fly = 1'b0;
		repeat (8) @(negedge clk);
		check(21'(offs), 21'h7f);
		end_sim;
	end
endmodule
`default_nettype wire
